// ---- design/pmsar_pkg.sv ----
// Purpose: Shared constants and types for the PHY management register view
// Assumes: Two copper ports, registers reached over the MII management pins
// Notes:   Bit positions are those of the 16-bit management words
package pmsar_pkg;
  localparam int         PORTS      = 2;
  // Port addresses and register numbers
  localparam logic [4:0] PHY_P1     = 5'h01;
  localparam logic [4:0] PHY_P2     = 5'h02;
  localparam logic [4:0] REG_STATUS = 5'h01;
  localparam logic [4:0] REG_ID_HI  = 5'h02;
  localparam logic [4:0] REG_ID_LO  = 5'h03;
  localparam logic [4:0] REG_ADV    = 5'h04;
  localparam logic [4:0] REG_LPA    = 5'h05;
  // Basic status word fields
  localparam int ST_100F    = 14;
  localparam int ST_100H    = 13;
  localparam int ST_10F     = 12;
  localparam int ST_10H     = 11;
  localparam int ST_AN_DONE = 5;
  localparam int ST_FEF     = 4;
  localparam int ST_AN_CAP  = 3;
  localparam int ST_LINK    = 2;
  localparam int ST_EXT     = 0;
  // Advertisement and partner ability fields
  localparam int AB_PAUSE   = 10;
  localparam int AB_100F    = 8;
  localparam int AB_10H     = 5;
  localparam logic [4:0] ADV_SELECTOR = 5'h01;
  localparam logic [4:0] ADV_RESET    = 5'h1f;
  // Frame layout
  localparam logic [5:0] PRE_LEN  = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h0b;
  localparam logic [5:0] DAT_LAST = 6'h0f;
  localparam logic [1:0] OP_RD    = 2'h2;
  localparam logic [1:0] OP_WR    = 2'h1;

  // Same bit order as the switch-side control bits 4..0
  typedef struct packed {
    logic pause;
    logic f100;
    logic h100;
    logic f10;
    logic h10;
  } pmsar_abil_t;

  typedef struct packed {
    logic        link_up;
    logic        an_done;
    logic        an_enable;
    pmsar_abil_t partner;
  } pmsar_port_st_t;

  typedef enum logic [2:0] {
    S_PRE, S_ST, S_HDR, S_TA, S_RD, S_WR
  } pmsar_state_t;

  typedef struct packed {
    logic [1:0]   mdc_s;
    logic [1:0]   mdio_s;
    logic         mdc_prev;
    pmsar_state_t st;
    logic [5:0]   cnt;
    logic [11:0]  hdr;
    logic [15:0]  data;
    logic         out;
    logic         oe;
    pmsar_abil_t  adv1;
    pmsar_abil_t  adv2;
  } pmsar_regs_t;
endpackage

// ---- design/pmsar_regs.sv ----
// Purpose: Management register view of two PHY ports, served over MDC/MDIO
// Assumes: MDC well below clock/4; switch-side inputs are on this clock
// Notes:   Advertisement bits are the switch-side control storage itself
// What this block does
// - Status bit 11, 10 Mb/s half-duplex capable, is constant 1.
// - Status bit 5 shows negotiation done; resets to 0.
// - Status bit 4 shows far-end fault, port 1 only.
// - Status bit 3 follows the port's negotiation enable setting.
// - Status bit 2 shows link up; resets to 0.
// - Link status equals the switch-side link state of each port.
// - Status bit 0 always reads 0, no extended registers.
// - Fixed identifier: high half at register 2, low at 3.
// - Advertisement at register 4 under port addresses 1 and 2.
// - Advertisement bit 10, pause, writable, resets to 1.
// - Advertisement bit 8, 100 full, writable, resets to 1.
// - Advertisement bit 7, 100 half, writable, resets to 1.
// - Advertisement bit 6, 10 full, writable, resets to 1.
// - Advertisement bit 5, 10 half, writable, resets to 1.
// - Advertisement bits share storage with switch-side control bits 4..0.
// - Partner word at register 5; bits 15 to 13 read 0.
// - Status bit 14, 100 Mb/s full-duplex capable, is constant 1.
`timescale 1ns/10ps
module pmsar_regs
  import pmsar_pkg::*;
#(
  parameter logic [15:0] ID_HIGH = 16'h1a2b,  // Arbitrary value
  parameter logic [15:0] ID_LOW  = 16'h3c4d   // Arbitrary value
) (
  // Clock and reset
  input  wire logic           clock,
  input  wire logic           rst_n,
  input  wire logic           clk_en,
  // Management pins
  input  wire logic           mdc,
  input  wire logic           mdio_i,
  output logic                mdio_o,
  output logic                mdio_oe,
  // Switch-side port status
  input  pmsar_port_st_t      port1_st,
  input  pmsar_port_st_t      port2_st,
  input  wire logic           far_end_fault,
  // Switch-side access to the advertisement storage
  input  wire logic [1:0]     sw_adv_we,
  input  pmsar_abil_t         sw_adv_wdata,
  output pmsar_abil_t         adv1,
  output pmsar_abil_t         adv2
);

  pmsar_regs_t q, d;

  logic mdc_rise;
  logic bit_in;
  logic hit;
  logic is_rd;
  logic port2;
  logic ld;
  logic commit;

  function automatic logic [15:0] ab_word(input pmsar_abil_t a);
    logic [15:0] w;
    w = '0;  // Reserved, next page, ack, remote fault stay 0
    w[AB_PAUSE] = a.pause;
    w[AB_100F:AB_10H] = {a.f100, a.h100, a.f10, a.h10};
    return w;
  endfunction

  function automatic logic [15:0] rd_word(input logic [4:0] rn,
                                          input logic p2,
                                          input pmsar_port_st_t s,
                                          input pmsar_abil_t a,
                                          input logic fef);
    logic [15:0] w;
    w = '0;
    case (rn)
      REG_STATUS: begin
        w[ST_100F]    = 1'b1;
        w[ST_100H]    = 1'b1;
        w[ST_10F]     = 1'b1;
        w[ST_10H]     = 1'b1;
        w[ST_AN_DONE] = s.an_done;
        w[ST_FEF]     = fef & ~p2;
        w[ST_AN_CAP]  = s.an_enable;
        w[ST_LINK]    = s.link_up;
        w[ST_EXT]     = 1'b0;
      end
      REG_ID_HI: w = ID_HIGH;
      REG_ID_LO: w = ID_LOW;
      REG_ADV: begin
        w = ab_word(a);
        w[4:0] = ADV_SELECTOR;
      end
      REG_LPA: w = ab_word(s.partner);
      default: w = '0;
    endcase
    return w;
  endfunction

  assign mdc_rise = q.mdc_s[1] & ~q.mdc_prev;
  assign bit_in   = q.mdio_s[1];
  assign is_rd    = (q.hdr[11:10] == OP_RD);
  assign port2    = (q.hdr[9:5] == PHY_P2);
  // Only registers 1..5 of ports 1 and 2 answer
  assign hit = ((q.hdr[9:5] == PHY_P1) || port2) &&
               (q.hdr[4:0] >= REG_STATUS) && (q.hdr[4:0] <= REG_LPA);
  assign ld     = mdc_rise && (q.st == S_TA) && (q.cnt == 6'h01) &&
                  is_rd && hit;
  assign commit = mdc_rise && (q.st == S_WR) && (q.cnt == DAT_LAST) &&
                  (q.hdr[11:10] == OP_WR) && hit &&
                  (q.hdr[4:0] == REG_ADV);

  always_comb begin
    d = q;
    d.mdc_s    = {q.mdc_s[0], mdc};
    d.mdio_s   = {q.mdio_s[0], mdio_i};
    d.mdc_prev = q.mdc_s[1];
    // Switch side writes first so a management write in the same cycle wins
    if (sw_adv_we[0]) begin
      d.adv1 = sw_adv_wdata;
    end
    if (sw_adv_we[1]) begin
      d.adv2 = sw_adv_wdata;
    end
    if (mdc_rise) begin
      case (q.st)
        S_PRE: begin
          if (bit_in) begin
            d.cnt = (q.cnt == PRE_LEN) ? q.cnt : q.cnt + 6'h01;
          end else begin
            d.st  = (q.cnt == PRE_LEN) ? S_ST : S_PRE;
            d.cnt = '0;
          end
        end
        S_ST: begin
          d.st  = bit_in ? S_HDR : S_PRE;
          d.cnt = '0;
        end
        S_HDR: begin
          d.hdr = {q.hdr[10:0], bit_in};
          d.cnt = q.cnt + 6'h01;
          if (q.cnt == HDR_LAST) begin
            d.st  = S_TA;
            d.cnt = '0;
          end
        end
        S_TA: begin
          d.cnt = q.cnt + 6'h01;
          if (q.cnt == 6'h00 && is_rd && hit) begin
            d.oe  = 1'b1;   // Drive the turnaround zero
            d.out = 1'b0;
          end
          if (q.cnt == 6'h01) begin
            d.cnt = '0;
            if (ld) begin
              d.data = rd_word(q.hdr[4:0], port2,
                               port2 ? port2_st : port1_st,
                               port2 ? q.adv2 : q.adv1,
                               far_end_fault);
              d.out  = d.data[15];
              d.st   = S_RD;
            end else begin
              // Unanswered reads simply fall back to preamble hunting
              d.st = is_rd ? S_PRE : S_WR;
            end
          end
        end
        S_RD: begin
          d.cnt  = q.cnt + 6'h01;
          d.data = {q.data[14:0], 1'b0};
          d.out  = q.data[14];
          if (q.cnt == DAT_LAST) begin
            d.oe  = 1'b0;
            d.out = 1'b0;
            d.st  = S_PRE;
            d.cnt = '0;
          end
        end
        S_WR: begin
          d.cnt  = q.cnt + 6'h01;
          d.data = {q.data[14:0], bit_in};
          if (q.cnt == DAT_LAST) begin
            d.st  = S_PRE;
            d.cnt = '0;
          end
          if (commit) begin
            // Only the five ability bits take a write
            d.adv2 = port2 ? {q.data[AB_PAUSE - 1],
                              q.data[AB_100F - 1:AB_10H - 1]}
                           : d.adv2;
            d.adv1 = port2 ? d.adv1
                           : {q.data[AB_PAUSE - 1],
                              q.data[AB_100F - 1:AB_10H - 1]};
          end
        end
        default: begin
          d.st  = S_PRE;
          d.cnt = '0;
          d.oe  = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q      <= '0;
      q.st   <= S_PRE;
      q.adv1 <= ADV_RESET;
      q.adv2 <= ADV_RESET;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign mdio_o  = q.out;
  assign mdio_oe = q.oe;
  assign adv1    = q.adv1;
  assign adv2    = q.adv2;

  // Checks
  logic [4:0] ld_reg;
  assign ld_reg = q.hdr[4:0];

  sequence s_load(logic [4:0] r);
    ld && clk_en && ld_reg == r;
  endsequence

  sequence s_loaded;
    ##1 q.st == S_RD && q.oe;
  endsequence

  // Frame steps: first turnaround edge of any frame, then each read data edge
  sequence s_ta_first;
    mdc_rise && clk_en && q.st == S_TA && q.cnt == 6'h00;
  endsequence

  sequence s_rd_edge;
    mdc_rise && clk_en && q.st == S_RD;
  endsequence

  property p_status_const;
    @(posedge clock) disable iff (!rst_n)
      s_load(REG_STATUS) |-> s_loaded and
        ##1 (q.data[ST_10H] && q.data[ST_100F] && !q.data[ST_EXT]);
  endproperty

  a_status_caps: assert property (p_status_const)
    else $error("status capability bits wrong");
  a_status_hundred: assert property (p_status_const)
    else $error("status 100 full bit wrong");
  a_status_ext: assert property (p_status_const)
    else $error("extended capable bit not zero");

  a_an_done_mirror: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_load(REG_STATUS) |=> q.data[ST_AN_DONE] ==
      $past(port2 ? port2_st.an_done : port1_st.an_done))
    else $error("negotiation done bit mismatch");

  a_far_end_port1: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_load(REG_STATUS) |=> q.data[ST_FEF] ==
      $past(far_end_fault && !port2))
    else $error("far-end fault bit mismatch");

  a_an_cap_mirror: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_load(REG_STATUS) |=> q.data[ST_AN_CAP] ==
      $past(port2 ? port2_st.an_enable : port1_st.an_enable))
    else $error("negotiation available bit mismatch");

  a_link_mirror: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_load(REG_STATUS) |=> q.data[ST_LINK] ==
      $past(port2 ? port2_st.link_up : port1_st.link_up))
    else $error("link status bit mismatch");

  a_ident_word: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_load(REG_ID_HI) |=> q.data == ID_HIGH && q.out == ID_HIGH[15])
    else $error("identifier high word wrong");

  a_ident_low: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_load(REG_ID_LO) |=> q.data == ID_LOW)
    else $error("identifier low word wrong");

  a_adv_selector: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_load(REG_ADV) |=> q.data[4:0] == ADV_SELECTOR &&
      q.data[15:11] == 5'h00 && !q.data[9])
    else $error("advertisement fixed fields wrong");

  a_lpa_unsup: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_load(REG_LPA) |=> q.data[15:13] == 3'h0)
    else $error("partner unsupported bits not zero");

  a_lpa_bits: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_load(REG_LPA) |=> {q.data[AB_PAUSE], q.data[AB_100F:AB_10H]} ==
      $past(port2 ? port2_st.partner : port1_st.partner))
    else $error("partner ability bits wrong");

  a_adv_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    commit && clk_en && !port2 |=> q.adv1 ==
      {$past(q.data[AB_PAUSE - 1]), $past(q.data[AB_100F - 1:AB_10H - 1])})
    else $error("advertisement write not stored");

  a_adv_write_p2: assert property (
    @(posedge clock) disable iff (!rst_n)
    commit && clk_en && port2 |=> q.adv2 ==
      {$past(q.data[AB_PAUSE - 1]), $past(q.data[AB_100F - 1:AB_10H - 1])})
    else $error("port 2 advertisement write not stored");

  a_sw_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    clk_en && sw_adv_we[1] && !(commit && port2) |=>
      q.adv2 == $past(sw_adv_wdata))
    else $error("switch-side write not stored");

  a_adv_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    clk_en && !sw_adv_we[0] && !(commit && !port2) |=>
      q.adv1 == $past(q.adv1))
    else $error("advertisement changed without a write");

  a_ta_drive: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_ta_first ##0 (is_rd && hit) |=> q.oe && !q.out)
    else $error("turnaround not driven low");

  a_ta_refused: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_ta_first ##0 !(is_rd && hit) |=> !q.oe)
    else $error("unanswered frame drives the data pin");

  a_turnaround: assert property (
    @(posedge clock) disable iff (!rst_n)
    ld && clk_en |-> q.oe && !q.out ##1 q.out == $past(d.data[15]))
    else $error("turnaround or first bit wrong");

  a_rd_shift: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_rd_edge ##0 q.cnt != DAT_LAST |=> q.oe && q.out == $past(q.data[14]))
    else $error("read data not shifted out in order");

  a_rd_release: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_rd_edge ##0 q.cnt == DAT_LAST |=> !q.oe && q.st == S_PRE)
    else $error("data pin not released after last bit");
endmodule

// ---- bench/pmsar_host.sv ----
// Purpose: Management station model that runs MDC/MDIO frames
// Assumes: MDC half period of 5 clocks, pins change at falling clock
// Notes:   A released line reads 1 through the MDIO pull-up
`timescale 1ns/10ps
module pmsar_host
  import pmsar_pkg::*;
(
  // Clock
  input  wire logic clock,
  // Management pins
  input  wire logic line,
  output logic      mdc,
  output logic      drv,
  output logic      drv_oe
);
  initial begin
    mdc    = 1'b0;
    drv    = 1'b1;
    drv_oe = 1'b0;
  end

  task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
                      input logic [4:0] rg, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [63:0] f;
    f  = {32'hffffffff, 2'b01, op, phy, rg, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      @(negedge clock);
      mdc    = 1'b0;
      // Reads hand the line over from the turnaround on
      drv_oe = !(op == OP_RD && i <= 17);
      drv    = f[i];
      repeat (5) @(negedge clock);
      mdc = 1'b1;
      if (i < 16) begin
        rd[i] = line;
      end
      repeat (4) @(negedge clock);
    end
    @(negedge clock);
    mdc    = 1'b0;
    drv_oe = 1'b0;
  endtask
endmodule

// ---- bench/pmsar_regs_tb.sv ----
// Purpose: Self-checking bench for the PHY management register view
// Assumes: Frames come from the station model, one at a time
// Notes:   Unanswered reads return all ones from the pull-up
`timescale 1ns/10ps
module pmsar_regs_tb
  import pmsar_pkg::*;
;
  localparam logic [15:0] IDH = 16'h5a3c;  // Arbitrary value
  localparam logic [15:0] IDL = 16'hc3a5;  // Arbitrary value
  logic           clock;
  logic           rst_n;
  logic           en;
  logic           mdc;
  logic           mdio_o;
  logic           mdio_oe;
  logic           drv;
  logic           drv_oe;
  logic           fef;
  wire            line;
  pmsar_port_st_t p1;
  pmsar_port_st_t p2;
  logic [1:0]     we;
  pmsar_abil_t    wdat;
  pmsar_abil_t    adv1;
  pmsar_abil_t    adv2;
  logic [15:0]    r;
  int             n_mismatch;
  int             check_count;
  int             cyc = 0;

  assign line = mdio_oe ? mdio_o : (drv_oe ? drv : 1'b1);

  pmsar_regs #(.ID_HIGH(IDH), .ID_LOW(IDL)) u_pmsar_regs (
    .clock(clock), .rst_n(rst_n), .clk_en(en), .mdc(mdc),
    .mdio_i(line), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .port1_st(p1), .port2_st(p2), .far_end_fault(fef),
    .sw_adv_we(we), .sw_adv_wdata(wdat), .adv1(adv1), .adv2(adv2));

  pmsar_host u_pmsar_host (
    .clock(clock), .line(line), .mdc(mdc), .drv(drv), .drv_oe(drv_oe));

  always #25 clock = ~clock;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdc(input logic [4:0] phy, rg, input logic [15:0] exp);
    u_pmsar_host.xfer(OP_RD, phy, rg, 16'h0000, r);
    chk(r, exp);
  endtask

  task automatic wr(input logic [4:0] phy, rg, input logic [15:0] wd);
    u_pmsar_host.xfer(OP_WR, phy, rg, wd, r);
    repeat (6) @(negedge clock);
  endtask

  function automatic logic [15:0] st_word(pmsar_port_st_t s, logic f);
    return 16'h7800 | {10'h000, s.an_done, f, s.an_enable, s.link_up, 2'b00};
  endfunction

  task automatic t_reset;
    chk({11'h000, adv1}, 16'h001f);
    chk({11'h000, adv2}, 16'h001f);
    rdc(PHY_P1, REG_ADV, 16'h05e1);
    rdc(PHY_P2, REG_ADV, 16'h05e1);
  endtask

  task automatic t_status;
    for (int k = 0; k < 2; k++) begin
      p1  = (k == 1) ? 8'hc0 : 8'h20;
      p2  = (k == 1) ? 8'h20 : 8'he0;
      fef = (k == 1);
      rdc(PHY_P1, REG_STATUS, st_word(p1, fef));
      rdc(PHY_P2, REG_STATUS, st_word(p2, 1'b0));
    end
  endtask

  task automatic t_ident;
    rdc(PHY_P1, REG_ID_HI, IDH);
    rdc(PHY_P2, REG_ID_LO, IDL);
  endtask

  task automatic t_adv;
    wr(PHY_P1, REG_ADV, 16'hffff);
    rdc(PHY_P1, REG_ADV, 16'h05e1);
    wr(PHY_P1, REG_ADV, 16'h0000);
    chk({11'h000, adv1}, 16'h0000);
    chk({11'h000, adv2}, 16'h001f);
    rdc(PHY_P1, REG_ADV, 16'h0001);
    wr(PHY_P2, REG_ADV, 16'h0140);
    chk({11'h000, adv2}, 16'h000a);
    // Switch side writes the same storage
    we   = 2'b01;
    wdat = 5'h15;
    @(negedge clock);
    we = 2'b00;
    rdc(PHY_P1, REG_ADV, 16'h04a1);
  endtask

  task automatic t_partner;
    p1.partner = 5'h1f;
    p2.partner = 5'h0a;
    rdc(PHY_P1, REG_LPA, 16'h05e0);
    rdc(PHY_P2, REG_LPA, 16'h0140);
  endtask

  task automatic t_refused;
    rdc(5'h03, REG_STATUS, 16'hffff);
    rdc(PHY_P1, 5'h00, 16'hffff);
    rdc(PHY_P1, 5'h06, 16'hffff);
    wr(PHY_P1, REG_LPA, 16'h0000);
    chk({11'h000, adv1}, 16'h0015);
    rdc(PHY_P2, REG_ID_HI, IDH);
  endtask

  // Clock enable low must hold every register, storage included
  task automatic t_freeze;
    en   = 1'b0;
    we   = 2'b10;
    wdat = 5'h00;
    @(negedge clock);
    we = 2'b00;
    @(negedge clock);
    chk({11'h000, adv2}, 16'h000a);
    en = 1'b1;
    @(negedge clock);
    chk({11'h000, adv2}, 16'h000a);
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Some 21 frames of about 650 clocks each
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      end_sim;
    end
  end

  initial begin
    clock       = 1'b0;
    rst_n       = 1'b0;
    p1          = 8'h00;
    p2          = 8'h00;
    fef         = 1'b0;
    we          = 2'b00;
    wdat        = 5'h00;
    n_mismatch  = 0;
    check_count = 0;
    en          = 1'b1;
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    t_reset;
    t_status;
    t_ident;
    t_adv;
    t_partner;
    t_refused;
    t_freeze;
    end_sim;
  end
endmodule
